/* File: hdl/bcd_adjust_and_file_decrement.sv */
`timescale 1ns/100ps
module bcd_adjust_and_file_decrement (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // instruction
  input wire logic [15:0] i_opcode,
  input wire logic i_extended_en,
  input wire logic [3:0] i_bank_pointer_reg,
  // data memory
  input wire logic [7:0] i_mem_rdata,
  output logic [11:0] o_mem_addr,
  output logic o_mem_indexed,
  output logic o_mem_rd,
  output logic [7:0] o_mem_wdata,
  output logic o_mem_wr,
  // accumulator and status
  output logic [7:0] o_acc,
  output logic o_carry,
  output logic o_half_byte_wrap_bit,
  output logic o_negative,
  output logic o_signed_wrap_flag,
  output logic o_zero,
  // phase
  output logic [1:0] o_phase
);
  phase_if ph ();
  phase_gen u_phase (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .ph(ph)
  );

  bcd_dec_pkg::op_kind_t op;
  bcd_dec_pkg::op_kind_t next_op;
  logic [15:0] opc;
  logic [15:0] next_opc;
  logic [7:0] operand;
  logic [7:0] next_operand;
  logic [7:0] result;
  logic [7:0] next_result;
  logic [7:0] acc;
  logic [7:0] next_acc;
  logic c, dc, n, ov, z;
  logic next_c, next_dc, next_n, next_ov, next_z;
  logic [11:0] addr;
  logic [11:0] next_addr;
  logic indexed;
  logic next_indexed;
  logic [7:0] wdata;
  logic [7:0] next_wdata;
  logic wr;
  logic next_wr;
  logic rd;

  // opcode class; anything unrecognised runs as a no-op
  function automatic bcd_dec_pkg::op_kind_t decode_op(input logic [15:0] code);
    if (code == bcd_dec_pkg::BCD_ADJUST_OPCODE) begin
      return bcd_dec_pkg::OP_BCD;
    end else if (code[bcd_dec_pkg::PREFIX_HI:bcd_dec_pkg::PREFIX_LO] ==
        bcd_dec_pkg::FILE_DEC_PREFIX) begin
      return bcd_dec_pkg::OP_DEC;
    end else begin
      return bcd_dec_pkg::OP_NONE;
    end
  endfunction

  // add the carry from below, then six when the nibble is past nine or forced;
  // bit 4 is the carry out into the next nibble
  function automatic logic [4:0] adjust_nibble(input logic [3:0] nib, input logic force_adj,
      input logic carry_in);
    logic [4:0] sum;
    sum = {1'b0, nib} + {4'h0, carry_in};
    if (nib > bcd_dec_pkg::NIBBLE_MAX || force_adj) begin
      sum = sum + {1'b0, bcd_dec_pkg::NIBBLE_CORR};
    end
    return sum;
  endfunction

  always_comb begin
    logic [7:0] fa;
    logic [4:0] lo_sum;
    logic [4:0] hi_sum;
    logic [3:0] lo_n;
    logic [3:0] hi_n;
    fa = i_opcode[bcd_dec_pkg::FILE_ADDR_HI:0];
    lo_sum = 5'h00;
    hi_sum = 5'h00;
    lo_n = 4'h0;
    hi_n = 4'h0;
    next_op = op;
    next_opc = opc;
    next_operand = operand;
    next_result = result;
    next_acc = acc;
    next_c = c;
    next_dc = dc;
    next_n = n;
    next_ov = ov;
    next_z = z;
    next_addr = addr;
    next_indexed = indexed;
    next_wdata = wdata;
    next_wr = 1'b0;
    // decode: latch the opcode and resolve the operand address
    if (ph.decode_en) begin
      next_op = decode_op(i_opcode);
      next_opc = i_opcode;
      next_indexed = 1'b0;
      if (i_opcode[bcd_dec_pkg::BANK_SEL_BIT]) begin
        next_addr = {i_bank_pointer_reg, fa};
      end else if (i_extended_en && fa <= bcd_dec_pkg::INDEXED_LIMIT) begin
        next_addr = {4'h0, fa};
        next_indexed = 1'b1;
      end else if (fa < bcd_dec_pkg::ACCESS_BANK_HI_MARK) begin
        next_addr = {bcd_dec_pkg::ACCESS_LOWER_BANK, fa};
      end else begin
        next_addr = {bcd_dec_pkg::ACCESS_UPPER_BANK, fa};
      end
    end

    // read: operand from memory for a decrement, else the accumulator
    if (ph.read_en) begin
      next_operand = (op == bcd_dec_pkg::OP_DEC) ? i_mem_rdata : acc;
    end

    // compute: bcd correction or decrement with its flags
    if (ph.process_en) begin
      if (op == bcd_dec_pkg::OP_BCD) begin
        lo_n = operand[3:0];
        hi_n = operand[7:4];
        lo_sum = adjust_nibble(lo_n, dc, 1'b0);
        hi_sum = adjust_nibble(hi_n, c, lo_sum[4]);
        if (hi_n > bcd_dec_pkg::NIBBLE_MAX || c) begin
          next_c = 1'b1;
        end
        next_result = {hi_sum[3:0], lo_sum[3:0]};
      end else if (op == bcd_dec_pkg::OP_DEC) begin
        next_result = operand - 8'h01;
        next_c = (operand != 8'h00);
        next_dc = (operand[3:0] != 4'h0);
        next_n = next_result[7];
        next_ov = (operand == 8'h80);
        next_z = (next_result == 8'h00);
      end
    end

    // write: result to the accumulator or back to the memory byte
    if (ph.write_en) begin
      if (op == bcd_dec_pkg::OP_BCD) begin
        next_acc = result;
      end else if (op == bcd_dec_pkg::OP_DEC) begin
        if (opc[bcd_dec_pkg::DEST_BIT]) begin
          next_wdata = result;
          next_wr = 1'b1;
        end else begin
          next_acc = result;
        end
      end
    end
  end

  // registers
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      op <= bcd_dec_pkg::OP_NONE;
      opc <= 16'h0000;
      operand <= 8'h00;
      result <= 8'h00;
      acc <= bcd_dec_pkg::ACC_RESET;
      c <= 1'b0;
      dc <= 1'b0;
      n <= 1'b0;
      ov <= 1'b0;
      z <= 1'b0;
      addr <= 12'h000;
      indexed <= 1'b0;
      wdata <= 8'h00;
      wr <= 1'b0;
    end else begin
      op <= next_op;
      opc <= next_opc;
      operand <= next_operand;
      result <= next_result;
      acc <= next_acc;
      c <= next_c;
      dc <= next_dc;
      n <= next_n;
      ov <= next_ov;
      z <= next_z;
      addr <= next_addr;
      indexed <= next_indexed;
      wdata <= next_wdata;
      wr <= next_wr;
    end
  end

  // outputs
  assign rd = ph.read_en && (op == bcd_dec_pkg::OP_DEC);
  assign o_mem_rd = rd;
  assign o_mem_addr = addr;
  assign o_mem_indexed = indexed;
  assign o_mem_wdata = wdata;
  assign o_mem_wr = wr;
  assign o_acc = acc;
  assign o_carry = c;
  assign o_half_byte_wrap_bit = dc;
  assign o_negative = n;
  assign o_signed_wrap_flag = ov;
  assign o_zero = z;
  assign o_phase = ph.phase;
endmodule

/* File: hdl/bcd_dec_pkg.sv */
package bcd_dec_pkg;
  // opcode field layout
  localparam int OPC_W = 16;
  localparam logic [15:0] BCD_ADJUST_OPCODE = 16'h0007;
  localparam logic [5:0] FILE_DEC_PREFIX = 6'h01;
  localparam int PREFIX_HI = 15;
  localparam int PREFIX_LO = 10;
  localparam int DEST_BIT = 9;
  localparam int BANK_SEL_BIT = 8;
  localparam int FILE_ADDR_HI = 7;
  // nibble correction
  localparam logic [3:0] NIBBLE_MAX = 4'h9;
  localparam logic [3:0] NIBBLE_CORR = 4'h6;
  // indexed literal offset limit
  localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
  // reset values, then the access bank split
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [1:0] PHASE_RESET = 2'h0;
  localparam logic [3:0] BANK_PTR_RESET = 4'h0;
  localparam logic [7:0] ACCESS_BANK_HI_MARK = 8'h60;
  localparam logic [3:0] ACCESS_UPPER_BANK = 4'hf;
  localparam logic [3:0] ACCESS_LOWER_BANK = 4'h0;
  typedef enum logic [1:0] {
    OP_NONE,
    OP_BCD,
    OP_DEC
  } op_kind_t;
endpackage

/* File: hdl/phase_if.sv */
`timescale 1ns/100ps
interface phase_if;
  logic [1:0] phase;
  logic decode_en;
  logic read_en;
  logic process_en;
  logic write_en;
  modport gen (output phase, output decode_en, output read_en, output process_en,
    output write_en);
  modport use_ph (input phase, input decode_en, input read_en, input process_en,
    input write_en);
endinterface

/* File: hdl/phase_gen.sv */
`timescale 1ns/100ps
module phase_gen (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // phase outputs
  phase_if.gen ph
);
  logic [1:0] phase;
  logic [1:0] next_phase;

  always_comb begin
    next_phase = phase + 2'h1;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      phase <= bcd_dec_pkg::PHASE_RESET;
    end else begin
      phase <= next_phase;
    end
  end

  assign ph.phase = phase;
  assign ph.decode_en = (phase == 2'h0);
  assign ph.read_en = (phase == 2'h1);
  assign ph.process_en = (phase == 2'h2);
  assign ph.write_en = (phase == 2'h3);
endmodule

/* File: bench/bcd_dec_properties.sv */
`timescale 1ns/100ps
module bcd_dec_properties (
  // inputs
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [15:0] i_opcode,
  input wire logic i_extended_en,
  input wire logic [3:0] i_bank_pointer_reg,
  input wire logic [7:0] i_mem_rdata,
  // outputs
  input wire logic [11:0] o_mem_addr,
  input wire logic o_mem_indexed,
  input wire logic o_mem_rd,
  input wire logic [7:0] o_mem_wdata,
  input wire logic o_mem_wr,
  input wire logic [7:0] o_acc,
  input wire logic o_carry,
  input wire logic o_half_byte_wrap_bit,
  input wire logic o_negative,
  input wire logic o_signed_wrap_flag,
  input wire logic o_zero,
  input wire logic [1:0] o_phase
);
  logic [15:0] op;
  logic ext;
  logic [3:0] bp;
  wire dec = op[15:10] == 6'h01;
  wire bcd = op == 16'h0007;
  wire idx = dec && !op[8] && ext && op[7:0] <= 8'h5f;
  wire bcd_lo_adj = o_acc[3:0] > 4'h9 || o_half_byte_wrap_bit;
  wire [4:0] lo = {1'b0, o_acc[3:0]} + (bcd_lo_adj ? 5'h06 : 5'h00);
  wire [3:0] hi = o_acc[7:4] + ((o_acc[7:4] > 4'h9 || o_carry) ? 4'h6 : 4'h0) + {3'h0, lo[4]};
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // operands as taken at the end of phase 0
  always_ff @(posedge i_core_clk) begin
    if (o_phase == 2'h0) begin
      op <= i_opcode;
      ext <= i_extended_en;
      bp <= i_bank_pointer_reg;
    end
  end
  property p_phase;
    o_phase == 2'h1 |=> o_phase == 2'h2 ##1 o_phase == 2'h3 ##1 o_phase == 2'h0;
  endproperty
  a_phase: assert property (p_phase) else $error("phase order");
  property p_idx;
    (o_phase == 2'h1 && dec) |-> o_mem_indexed == idx && (!idx || o_mem_addr[7:0] == op[7:0]);
  endproperty
  a_idx: assert property (p_idx) else $error("indexed access");
  property p_access;
    (o_phase == 2'h1 && dec && !op[8] && !idx) |->
      o_mem_addr == {(op[7:0] < 8'h60) ? 4'h0 : 4'hf, op[7:0]};
  endproperty
  a_access: assert property (p_access) else $error("access bank address");
  property p_bank;
    (o_phase == 2'h1 && dec && op[8]) |-> o_mem_addr == {bp, op[7:0]} && o_mem_rd;
  endproperty
  a_bank: assert property (p_bank) else $error("bank pointer address");
  property p_dval;
    (o_phase == 2'h1 && dec) |-> ##3 (op[9] ? o_mem_wdata : o_acc) == $past(i_mem_rdata, 3) - 8'h01;
  endproperty
  a_dval: assert property (p_dval) else $error("decrement result");
  property p_wr;
    o_mem_wr == ($past(o_phase) == 2'h3 && dec && op[9]);
  endproperty
  a_wr: assert property (p_wr) else $error("write back pulse");
  property p_dflag;
    (o_phase == 2'h1 && dec) |-> ##2 (o_zero == ($past(i_mem_rdata, 2) == 8'h01)
      && o_carry == ($past(i_mem_rdata, 2) != 8'h00));
  endproperty
  a_dflag: assert property (p_dflag) else $error("decrement flags");
  property p_bval;
    (o_phase == 2'h3 && bcd) |=> o_acc == $past({hi, lo[3:0]});
  endproperty
  a_bval: assert property (p_bval) else $error("bcd adjust value");
  property p_bflag;
    (o_phase == 2'h2 && bcd) |=> (o_carry || !$past(o_carry))
      && $stable({o_zero, o_negative, o_signed_wrap_flag, o_half_byte_wrap_bit});
  endproperty
  a_bflag: assert property (p_bflag) else $error("bcd adjust flags");
endmodule
bind bcd_adjust_and_file_decrement bcd_dec_properties bcd_dec_properties_i (
  .i_core_clk(i_core_clk),
  .i_reset(i_reset),
  .i_opcode(i_opcode),
  .i_extended_en(i_extended_en),
  .i_bank_pointer_reg(i_bank_pointer_reg),
  .i_mem_rdata(i_mem_rdata),
  .o_mem_addr(o_mem_addr),
  .o_mem_indexed(o_mem_indexed),
  .o_mem_rd(o_mem_rd),
  .o_mem_wdata(o_mem_wdata),
  .o_mem_wr(o_mem_wr),
  .o_acc(o_acc),
  .o_carry(o_carry),
  .o_half_byte_wrap_bit(o_half_byte_wrap_bit),
  .o_negative(o_negative),
  .o_signed_wrap_flag(o_signed_wrap_flag),
  .o_zero(o_zero),
  .o_phase(o_phase)
);

/* File: bench/bcd_adjust_and_file_decrement_tb.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; $display("BAD %0t %h %h", $time, a, b); end end
module bcd_adjust_and_file_decrement_tb;
  typedef struct packed {
    logic [15:0] op;
    logic [7:0] rd;
    logic ext;
    logic [3:0] bp;
    logic [7:0] acc;
    logic [4:0] fl;
    logic wr;
    logic [12:0] ad;
  } row_t;
  logic i_core_clk, i_reset, i_extended_en, o_mem_indexed, o_mem_rd, o_mem_wr;
  logic o_carry, o_half_byte_wrap_bit, o_negative, o_signed_wrap_flag, o_zero;
  logic [15:0] i_opcode;
  logic [3:0] i_bank_pointer_reg;
  logic [7:0] i_mem_rdata, o_mem_wdata, o_acc;
  logic [11:0] o_mem_addr;
  logic [1:0] o_phase;
  int err_count = 0;
  int checks = 0;
  wire [4:0] flags = {o_carry, o_half_byte_wrap_bit, o_negative, o_signed_wrap_flag, o_zero};
  // flags column: carry, half-byte, negative, signed wrap, zero
  // ad column: indexed bit then address, looked at for decrements only
  row_t rows [10] = '{
    '{16'h0536, 8'h36, 1'b1, 4'h3, 8'h35, 5'h18, 1'b0, 13'h0336},
    '{16'h0007, 8'h00, 1'b0, 4'h0, 8'h9b, 5'h18, 1'b0, 13'h0000},
    '{16'h0680, 8'h80, 1'b0, 4'h5, 8'h9b, 5'h12, 1'b1, 13'h0f80},
    '{16'h0410, 8'h01, 1'b1, 4'h0, 8'h00, 5'h19, 1'b0, 13'h1010},
    '{16'h0007, 8'h00, 1'b1, 4'h0, 8'h66, 5'h19, 1'b0, 13'h0000},
    '{16'h0420, 8'h00, 1'b0, 4'h0, 8'hff, 5'h04, 1'b0, 13'h0020},
    '{16'h1234, 8'h55, 1'b0, 4'h0, 8'hff, 5'h04, 1'b0, 13'h0000},
    '{16'h0007, 8'h00, 1'b0, 4'h0, 8'h65, 5'h14, 1'b0, 13'h0000},
    '{16'h0460, 8'h10, 1'b1, 4'h0, 8'h0f, 5'h10, 1'b0, 13'h0f60},
    '{16'h065f, 8'h5f, 1'b1, 4'h7, 8'h0f, 5'h18, 1'b1, 13'h105f}
  };
  bcd_adjust_and_file_decrement bcd_adjust_and_file_decrement_i (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_opcode(i_opcode),
    .i_extended_en(i_extended_en),
    .i_bank_pointer_reg(i_bank_pointer_reg),
    .i_mem_rdata(i_mem_rdata),
    .o_mem_addr(o_mem_addr),
    .o_mem_indexed(o_mem_indexed),
    .o_mem_rd(o_mem_rd),
    .o_mem_wdata(o_mem_wdata),
    .o_mem_wr(o_mem_wr),
    .o_acc(o_acc),
    .o_carry(o_carry),
    .o_half_byte_wrap_bit(o_half_byte_wrap_bit),
    .o_negative(o_negative),
    .o_signed_wrap_flag(o_signed_wrap_flag),
    .o_zero(o_zero),
    .o_phase(o_phase)
  );
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end
  task test_done;
    if (err_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one instruction launched at the edge ending phase 3, results seen in next phase 0
  task run(input row_t r);
    int n;
    n = 0;
    while (o_phase !== 2'h3 && n < 8) begin
      @(negedge i_core_clk);
      n++;
    end
    if (o_phase !== 2'h3) err_count++;
    @(posedge i_core_clk);
    i_opcode <= r.op;
    i_mem_rdata <= r.rd;
    i_extended_en <= r.ext;
    i_bank_pointer_reg <= r.bp;
    @(posedge i_core_clk);
    i_opcode <= 16'h0000;
    @(negedge i_core_clk);
    `CHK(o_mem_rd, r.op[15:10] == 6'h01)
    repeat (3) @(posedge i_core_clk);
    @(negedge i_core_clk);
    `CHK(o_acc, r.acc)
    `CHK(flags, r.fl)
    `CHK(o_mem_wr, r.wr)
    if (r.wr) `CHK(o_mem_wdata, r.rd - 8'h01)
    if (r.op[15:10] == 6'h01) `CHK({o_mem_indexed, o_mem_addr}, r.ad)
  endtask
  initial begin
    i_reset = 1'b1;
    i_opcode = 16'h0000;
    i_extended_en = 1'b0;
    i_bank_pointer_reg = 4'h0;
    i_mem_rdata = 8'h00;
    repeat (10) @(posedge i_core_clk);
    @(negedge i_core_clk);
    `CHK({o_acc, flags, o_phase, o_mem_wr}, 16'h0000)
    @(posedge i_core_clk);
    i_reset <= 1'b0;
    @(negedge i_core_clk);
    foreach (rows[k]) run(rows[k]);
    // reset in mid-run clears the accumulator and flags
    @(posedge i_core_clk);
    i_reset <= 1'b1;
    @(posedge i_core_clk);
    i_reset <= 1'b0;
    @(negedge i_core_clk);
    `CHK({o_acc, flags, o_phase, o_mem_wr}, 16'h0000)
    run(rows[0]);
    test_done;
  end
  initial begin
    repeat (1000) @(posedge i_core_clk);
    err_count++;
    test_done;
  end
endmodule
